// >>> pkg/ptf_params.svh
// constants of the pulse telegram payload framer
// assumes inclusion by bare name from the design file
`ifndef PTF_PARAMS_SVH
`define PTF_PARAMS_SVH
// ==========================================
// block codes
`define PTF_MSG_FORMAT 8'h2d
`define PTF_DIF_INT32 8'h84
`define PTF_DIFE_2ND 8'h40
`define PTF_DIFE_CH1 8'h80
`define PTF_DIFE_CH2 8'hc0
`define PTF_VIF_M3_BASE 8'h16
`define PTF_VIF_MWH_BASE 8'h09
`define PTF_VIF_EXT 8'hfd
`define PTF_VIFE_NOUNIT 8'h3a
`define PTF_DT_DIF 8'h04
`define PTF_DT_VIF 8'h6d
`define PTF_COOL_DIF_OK 8'h84
`define PTF_COOL_DIF_ERR 8'hb4
// ==========================================
// sizes
`define PTF_FRAME_MAX 33
`define PTF_LEN_W 6
// ==========================================
// date/time word field positions (lsb)
`define PTF_DT_YHI 28
`define PTF_DT_MON 24
`define PTF_DT_YLO 21
`define PTF_DT_DAY 16
`define PTF_DT_SUMMER 15
`define PTF_DT_CENT 13
`define PTF_DT_HOUR 8
`define PTF_DT_ERR 7
`define PTF_DT_INVALID 6
`define PTF_DT_MIN 0
`endif

// >>> pkg/ptf_pkg.sv
// types of the pulse telegram payload framer
// assumes ptf_params.svh is on the include path
`include "ptf_params.svh"
package ptf_pkg;
  // ==========================================
  // types
  typedef enum logic [1:0] {
    PTF_UNIT_M3 = 2'h0,
    PTF_UNIT_MWH = 2'h1,
    PTF_UNIT_NONE = 2'h2
  } ptf_unit_e;
  typedef enum logic [1:0] {
    PTF_ST_IDLE = 2'b01,
    PTF_ST_SEND = 2'b10
  } ptf_state_e;
  typedef struct packed {
    logic [2:0] len;
    logic [4:0][7:0] b;
  } ptf_hdr_s;
  typedef logic [`PTF_FRAME_MAX-1:0][7:0] ptf_frame_t;
endpackage

// >>> design/ptf_framer.sv
// pulse-input telegram payload framer: byte stream of data blocks
// assumes a byte sink with valid/ready and inputs synchronous to clk
`timescale 1ns/1ps
`include "ptf_params.svh"
module ptf_framer #(
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // frame request
  input wire logic frame_start,
  output logic frame_busy,
  // pulse counters
  input wire logic [31:0] pulse_count_0,
  input wire logic [31:0] pulse_count_1,
  input wire logic [31:0] pulse_count_2,
  input wire ptf_pkg::ptf_unit_e pulse_unit_0,
  input wire ptf_pkg::ptf_unit_e pulse_unit_1,
  input wire ptf_pkg::ptf_unit_e pulse_unit_2,
  input wire logic [1:0] pulse_dec_0,
  input wire logic [1:0] pulse_dec_1,
  input wire logic [1:0] pulse_dec_2,
  // meter date and time
  input wire logic [6:0] time_year,
  input wire logic [3:0] time_month,
  input wire logic [4:0] time_day,
  input wire logic [4:0] time_hour,
  input wire logic [5:0] time_minute,
  input wire logic [1:0] time_century,
  input wire logic time_summer,
  input wire logic time_valid,
  input wire logic time_error,
  // cooling field marking
  input wire logic meter_combined,
  output logic [7:0] cool_dif,
  // byte stream out
  output logic [7:0] out_byte,
  output logic out_last,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================
  // header builder
  function automatic ptf_pkg::ptf_hdr_s unit_hdr(
    input logic [1:0] ch,
    input ptf_pkg::ptf_unit_e unit,
    input logic [1:0] dec
  );
    ptf_pkg::ptf_hdr_s h;
    logic [1:0] d;
    logic [2:0] n;
    h = '0;
    h.b[0] = `PTF_DIF_INT32;
    if (ch == 2'h0) begin
      h.b[1] = `PTF_DIFE_2ND;
      n = 3'h2;
    end else begin
      h.b[1] = (ch == 2'h1) ? `PTF_DIFE_CH1 : `PTF_DIFE_CH2;
      h.b[2] = `PTF_DIFE_2ND;
      n = 3'h3;
    end
    // an unused decimal code of 0 is sent as three decimals
    d = (dec == 2'h0) ? 2'h3 : dec;
    case (unit)
      ptf_pkg::PTF_UNIT_M3: begin
        h.b[n] = `PTF_VIF_M3_BASE - {6'h00, d};
        n = n + 3'h1;
      end
      ptf_pkg::PTF_UNIT_MWH: begin
        // MWh has no one-decimal code, so it falls back to two
        if (d == 2'h1) begin
          d = 2'h2;
        end
        h.b[n] = `PTF_VIF_MWH_BASE - {6'h00, d};
        n = n + 3'h1;
      end
      default: begin
        h.b[n] = `PTF_VIF_EXT;
        h.b[n + 3'h1] = `PTF_VIFE_NOUNIT;
        n = n + 3'h2;
      end
    endcase
    h.len = n;
    return h;
  endfunction

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(BUF_DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // ==========================================
  // state
  ptf_pkg::ptf_state_e state_reg;
  ptf_pkg::ptf_frame_t frame_reg;
  ptf_pkg::ptf_frame_t frame_next;
  logic [`PTF_LEN_W-1:0] len_reg;
  logic [`PTF_LEN_W-1:0] len_next;
  logic [`PTF_LEN_W-1:0] idx_reg;
  logic [31:0] dt_word;
  logic [2:0][31:0] counts;
  ptf_pkg::ptf_unit_e units [3];
  logic [2:0][1:0] decs;
  logic take;
  logic push;
  logic pop;
  logic push_last;
  logic [8:0] buf_mem [BUF_DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] cnt_reg;

  assign counts = {pulse_count_2, pulse_count_1, pulse_count_0};
  assign decs = {pulse_dec_2, pulse_dec_1, pulse_dec_0};
  assign units[0] = pulse_unit_0;
  assign units[1] = pulse_unit_1;
  assign units[2] = pulse_unit_2;

  // ==========================================
  // date/time word
  always_comb begin
    dt_word = '0;
    dt_word[`PTF_DT_YHI +: 4] = time_year[6:3];
    dt_word[`PTF_DT_MON +: 4] = time_month;
    dt_word[`PTF_DT_YLO +: 3] = time_year[2:0];
    dt_word[`PTF_DT_DAY +: 5] = time_day;
    dt_word[`PTF_DT_SUMMER] = time_summer;
    dt_word[`PTF_DT_CENT +: 2] = time_century;
    dt_word[`PTF_DT_HOUR +: 5] = time_hour;
    dt_word[`PTF_DT_ERR] = time_error;
    dt_word[`PTF_DT_INVALID] = ~time_valid;
    dt_word[`PTF_DT_MIN +: 6] = time_minute;
  end

  // ==========================================
  // frame image, values least significant byte first
  always_comb begin
    ptf_pkg::ptf_hdr_s h;
    int n;
    h = '0;
    n = 0;
    frame_next = '0;
    frame_next[0] = `PTF_MSG_FORMAT;
    n = 1;
    for (int c = 0; c < 3; c++) begin
      h = unit_hdr(2'(c), units[c], decs[c]);
      for (int i = 0; i < 5; i++) begin
        if (i < int'(h.len)) begin
          frame_next[n] = h.b[i];
          n++;
        end
      end
      for (int i = 0; i < 4; i++) begin
        frame_next[n] = counts[c][8*i +: 8];
        n++;
      end
    end
    frame_next[n] = `PTF_DT_DIF;
    frame_next[n+1] = `PTF_DT_VIF;
    for (int i = 0; i < 4; i++) begin
      frame_next[n+2+i] = dt_word[8*i +: 8];
    end
    len_next = `PTF_LEN_W'(n + 6);
  end

  // ==========================================
  // sequencer
  // inputs are snapshotted at the start so a frame never mixes samples
  assign frame_busy = (state_reg != ptf_pkg::PTF_ST_IDLE);
  assign take = frame_start && !frame_busy;
  assign push = (state_reg == ptf_pkg::PTF_ST_SEND) && (cnt_reg != (PW+1)'(BUF_DEPTH));
  assign push_last = (idx_reg == len_reg - `PTF_LEN_W'(1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ptf_pkg::PTF_ST_IDLE;
    end else begin
      case (state_reg)
        ptf_pkg::PTF_ST_IDLE: begin
          if (take) begin
            state_reg <= ptf_pkg::PTF_ST_SEND;
          end
        end
        ptf_pkg::PTF_ST_SEND: begin
          if (push && push_last) begin
            state_reg <= ptf_pkg::PTF_ST_IDLE;
          end
        end
        default: begin
          state_reg <= ptf_pkg::PTF_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_reg <= '0;
      len_reg <= '0;
    end else if (take) begin
      frame_reg <= frame_next;
      len_reg <= len_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_reg <= '0;
    end else if (take) begin
      idx_reg <= '0;
    end else if (push) begin
      idx_reg <= idx_reg + `PTF_LEN_W'(1);
    end
  end

  // ==========================================
  // cooling field marking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cool_dif <= `PTF_COOL_DIF_ERR;
    end else begin
      cool_dif <= meter_combined ? `PTF_COOL_DIF_OK : `PTF_COOL_DIF_ERR;
    end
  end

  // ==========================================
  // output buffer: a sink stall holds the sequencer, no byte is lost
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_reg != '0);
  assign out_byte = buf_mem[rd_ptr_reg][7:0];
  assign out_last = buf_mem[rd_ptr_reg][8];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_mem[i] <= '0;
      end
    end else if (push) begin
      buf_mem[wr_ptr_reg] <= {push_last, frame_reg[idx_reg]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + (PW+1)'(1);
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - (PW+1)'(1);
      end
    end
  end

  // ==========================================
  // checks
  logic [31:0] dt_seen;
  assign dt_seen = {frame_reg[len_reg - `PTF_LEN_W'(1)], frame_reg[len_reg - `PTF_LEN_W'(2)],
                    frame_reg[len_reg - `PTF_LEN_W'(3)], frame_reg[len_reg - `PTF_LEN_W'(4)]};

  sequence s_take;
    frame_start && !frame_busy;
  endsequence
  sequence s_first_push;
    ##1 (push && idx_reg == '0);
  endsequence
  // a full buffer at the take delays the first push, so only the not-full case is timed
  property p_format;
    s_take ##0 (cnt_reg != (PW+1)'(BUF_DEPTH)) |-> s_first_push ##0 (frame_reg[idx_reg] == `PTF_MSG_FORMAT);
  endproperty
  a_format: assert property (p_format) else $error("format byte wrong");
  property p_c1_m3;
    s_take ##0 (pulse_unit_0 == ptf_pkg::PTF_UNIT_M3 && pulse_dec_0 == 2'h3)
      |=> frame_reg[1] == 8'h84 && frame_reg[2] == 8'h40 && frame_reg[3] == 8'h13;
  endproperty
  a_c1_m3: assert property (p_c1_m3) else $error("counter one m3 header wrong");
  property p_c1_mwh;
    s_take ##0 (pulse_unit_0 == ptf_pkg::PTF_UNIT_MWH && pulse_dec_0 == 2'h2)
      |=> frame_reg[3] == 8'h07 && frame_reg[4] == $past(pulse_count_0[7:0]);
  endproperty
  a_c1_mwh: assert property (p_c1_mwh) else $error("counter one MWh header wrong");
  property p_c1_none;
    s_take ##0 (pulse_unit_0 == ptf_pkg::PTF_UNIT_NONE)
      |=> frame_reg[3] == 8'hfd && frame_reg[4] == 8'h3a && frame_reg[8] == $past(pulse_count_0[31:24]);
  endproperty
  a_c1_none: assert property (p_c1_none) else $error("counter one plain header wrong");
  property p_c2_m3;
    s_take ##0 (pulse_unit_0 == ptf_pkg::PTF_UNIT_NONE && pulse_unit_1 == ptf_pkg::PTF_UNIT_M3
      && pulse_dec_1 == 2'h1) |=> frame_reg[9] == 8'h84 && frame_reg[10] == 8'h80
      && frame_reg[11] == 8'h40 && frame_reg[12] == 8'h15;
  endproperty
  a_c2_m3: assert property (p_c2_m3) else $error("counter two m3 header wrong");
  property p_c2_mwh;
    s_take ##0 (pulse_unit_0 == ptf_pkg::PTF_UNIT_NONE && pulse_unit_1 == ptf_pkg::PTF_UNIT_MWH
      && pulse_dec_1 == 2'h3) |=> frame_reg[12] == 8'h06;
  endproperty
  a_c2_mwh: assert property (p_c2_mwh) else $error("counter two MWh header wrong");
  property p_c2_none;
    s_take ##0 (pulse_unit_0 == ptf_pkg::PTF_UNIT_NONE && pulse_unit_1 == ptf_pkg::PTF_UNIT_NONE)
      |=> frame_reg[12] == 8'hfd && frame_reg[13] == 8'h3a;
  endproperty
  a_c2_none: assert property (p_c2_none) else $error("counter two plain header wrong");
  property p_c3;
    s_take ##0 (pulse_unit_0 == ptf_pkg::PTF_UNIT_M3 && pulse_unit_1 == ptf_pkg::PTF_UNIT_M3
      && pulse_dec_2 == 2'h2) |=> frame_reg[16] == 8'h84 && frame_reg[17] == 8'hc0
      && frame_reg[18] == 8'h40 && (frame_reg[19] == 8'h14 || frame_reg[19] == 8'h07
      || (frame_reg[19] == 8'hfd && frame_reg[20] == 8'h3a));
  endproperty
  a_c3: assert property (p_c3) else $error("counter three header wrong");
  property p_dt_block;
    s_take |=> frame_reg[len_reg - `PTF_LEN_W'(6)] == 8'h04 && frame_reg[len_reg - `PTF_LEN_W'(5)] == 8'h6d;
  endproperty
  a_dt_block: assert property (p_dt_block) else $error("date block header wrong");
  property p_dt_fields;
    s_take |=> {dt_seen[31:28], dt_seen[23:21]} == $past(time_year) && dt_seen[27:24] == $past(time_month)
      && dt_seen[20:16] == $past(time_day) && dt_seen[12:8] == $past(time_hour)
      && dt_seen[14:13] == $past(time_century);
  endproperty
  a_dt_fields: assert property (p_dt_fields) else $error("date fields misplaced");
  property p_dt_flags;
    s_take |=> dt_seen[15] == $past(time_summer) && dt_seen[6] == !$past(time_valid)
      && dt_seen[7] == $past(time_error) && dt_seen[5:0] == $past(time_minute);
  endproperty
  a_dt_flags: assert property (p_dt_flags) else $error("date flags wrong");
  property p_cool;
    !meter_combined ##1 !meter_combined |-> cool_dif[5:4] == 2'b11 ##1 (meter_combined || cool_dif[5:4] == 2'b11);
  endproperty
  a_cool: assert property (p_cool) else $error("cooling field not marked");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_byte) && $stable(out_last);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled byte changed");
endmodule

// >>> bench/ptf_uplink_sink.sv
// byte sink standing in for the radio uplink side of the framer
// assumes the framer's valid/ready stream and a single clock
`timescale 1ns/1ps
module ptf_uplink_sink (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // byte stream from framer
  input wire logic [7:0] in_byte,
  input wire logic in_last,
  input wire logic in_valid,
  output logic in_ready,
  // behaviour control
  input wire logic stall_en
);
  // ==========================================
  // received bytes, read by the bench
  logic [7:0] got_q[$];
  logic got_l[$];

  initial in_ready = 1'b0;

  // random stalls so the two-entry buffer fills and the sequencer waits
  always @(negedge clk) begin
    in_ready <= rst_n && (!stall_en || ($urandom % 3 != 0));
  end

  always @(posedge clk) begin
    if (rst_n && in_valid && in_ready) begin
      got_q.push_back(in_byte);
      got_l.push_back(in_last);
    end
  end
endmodule

// >>> bench/tb.sv
// self-checking bench of the pulse telegram payload framer
// assumes ptf_pkg compiled first and the sink model beside it
`timescale 1ns/1ps
module tb;
  // ==========================================
  // signals
  logic clk, rst_n, frame_start, frame_busy, meter_combined, stall_en;
  logic [31:0] cnt [3];
  ptf_pkg::ptf_unit_e unit [3];
  logic [1:0] dec [3];
  logic [6:0] yr;
  logic [3:0] mon;
  logic [4:0] day, hr;
  logic [5:0] mn;
  logic [1:0] cent;
  logic summer, tvalid, terr;
  logic [7:0] cool_dif, out_byte;
  logic out_last, out_valid, out_ready;
  logic [7:0] exp_q[$];
  logic exp_l[$];
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;

  ptf_framer uut (.clk(clk), .rst_n(rst_n), .frame_start(frame_start), .frame_busy(frame_busy),
    .pulse_count_0(cnt[0]), .pulse_count_1(cnt[1]), .pulse_count_2(cnt[2]),
    .pulse_unit_0(unit[0]), .pulse_unit_1(unit[1]), .pulse_unit_2(unit[2]),
    .pulse_dec_0(dec[0]), .pulse_dec_1(dec[1]), .pulse_dec_2(dec[2]),
    .time_year(yr), .time_month(mon), .time_day(day), .time_hour(hr), .time_minute(mn),
    .time_century(cent), .time_summer(summer), .time_valid(tvalid), .time_error(terr),
    .meter_combined(meter_combined), .cool_dif(cool_dif),
    .out_byte(out_byte), .out_last(out_last), .out_valid(out_valid), .out_ready(out_ready));

  ptf_uplink_sink sink (.clk(clk), .rst_n(rst_n), .in_byte(out_byte), .in_last(out_last),
    .in_valid(out_valid), .in_ready(out_ready), .stall_en(stall_en));

  // ==========================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      complete_run;
    end
  end

  // ==========================================
  // helpers
  task automatic complete_run;
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic push8(input logic [7:0] b);
    exp_q.push_back(b);
    exp_l.push_back(1'b0);
  endtask

  // values go out least significant byte first
  task automatic push32(input logic [31:0] v);
    for (int k = 0; k < 4; k++) begin
      push8(v[8*k +: 8]);
    end
  endtask

  // decimal code 0 reads as three, MWh with one decimal as two
  function automatic logic [7:0] vif_code(input logic [1:0] u, input logic [1:0] d);
    if (u == 2'h0) begin
      return (d == 2'h2) ? 8'h14 : (d == 2'h1) ? 8'h15 : 8'h13;
    end
    return (d == 2'h3 || d == 2'h0) ? 8'h06 : 8'h07;
  endfunction

  task automatic build_frame;
    logic [1:0] u;
    push8(8'h2d);
    for (int c = 0; c < 3; c++) begin
      u = unit[c];
      push8(8'h84);
      if (c == 1) push8(8'h80);
      if (c == 2) push8(8'hc0);
      push8(8'h40);
      if (u[1]) begin
        push8(8'hfd);
        push8(8'h3a);
      end else begin
        push8(vif_code(u, dec[c]));
      end
      push32(cnt[c]);
    end
    push8(8'h04);
    push8(8'h6d);
    push32({yr[6:3], mon, yr[2:0], day, summer, cent, hr, terr, ~tvalid, mn});
    exp_l[exp_l.size()-1] = 1'b1;
  endtask

  task automatic scramble;
    for (int c = 0; c < 3; c++) begin
      cnt[c] = $urandom;
      unit[c] = ptf_pkg::ptf_unit_e'(2'($urandom));
      dec[c] = 2'($urandom);
    end
    {yr, mon, day, hr, mn, cent, summer, tvalid, terr} = $urandom;
  endtask

  // first 16 frames sweep every unit and decimal code on each counter
  task automatic run_frame(input int f);
    scramble;
    if (f < 16) begin
      // counters one and two walk all unit pairs so every fixed-offset header check is reached
      unit[0] = ptf_pkg::ptf_unit_e'(2'(f % 4));
      unit[1] = ptf_pkg::ptf_unit_e'(2'(f / 4 % 4));
      unit[2] = ptf_pkg::ptf_unit_e'(2'((f + f / 4) % 4));
      dec[0] = 2'(f / 4 % 4);
      dec[1] = 2'((f % 4 + 2 * (f / 4) + 3) % 4);
      dec[2] = 2'((f + 2) % 4);
    end
    if (f == 0) yr = 7'h12;
    frame_start = 1'b1;
    build_frame;
    @(negedge clk);
    check(frame_busy === 1'b1, "busy after take");
    // held request while busy must be ignored; inputs change after sampling
    scramble;
    repeat (2) @(negedge clk);
    frame_start = 1'b0;
    for (int k = 0; k < 400 && frame_busy !== 1'b0; k++) begin
      @(negedge clk);
    end
    check(frame_busy === 1'b0, "frame never ended");
  endtask

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(63));
    rst_n = 1'b0;
    frame_start = 1'b0;
    stall_en = 1'b0;
    meter_combined = 1'b0;
    scramble;
    repeat (4) @(negedge clk);
    check(cool_dif === 8'hb4, "cooling marking in reset");
    rst_n = 1'b1;
    for (int f = 0; f < 20; f++) begin
      stall_en = f[0];
      meter_combined = 1'($urandom);
      @(negedge clk);
      check(cool_dif === (meter_combined ? 8'h84 : 8'hb4), "cooling marking");
      run_frame(f);
    end
    for (int k = 0; k < 400 && (out_valid !== 1'b0 || sink.got_q.size() < exp_q.size()); k++) begin
      @(negedge clk);
    end
    check(sink.got_q.size() == exp_q.size(), "payload length");
    for (int i = 0; i < exp_q.size() && i < sink.got_q.size(); i++) begin
      check(sink.got_q[i] === exp_q[i], "payload byte");
      check(sink.got_l[i] === exp_l[i], "last marker");
    end
    complete_run;
  end
endmodule
